// ---- core/acs_map.svh ----
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_OFF_SC1 8'h00
`define ACS_OFF_SC2 8'h04
`define ACS_OFF_SC3 8'h08
`define ACS_OFF_SC4 8'h0c
`define ACS_OFF_RES 8'h10
`define ACS_OFF_CV 8'h14
`define ACS_CHAN_OFF 5'h1f
`define ACS_MODE_8 2'h0
`define ACS_MODE_10 2'h2
`define ACS_SRC_ASYNC 2'h3
`define ACS_SRC_HALF 2'h1
`define ACS_CLK_MHZ 25
`define ACS_STARTUP_NS 5000
`define ACS_STARTUP_CYC ((`ACS_STARTUP_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_BUS_CYC 5
`define ACS_FIRST_EXTRA 3
`define ACS_SAMP_SHORT 4
`define ACS_SAMP_LONG 24
`define ACS_SUB_8S 17
`define ACS_SUB_HS 20
`define ACS_SUB_8L 37
`define ACS_SUB_HL 40
`endif

// ---- core/acs_pkg.sv ----
package acs_pkg;
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_WARM = 2'b01,
      ACS_SAMPLE = 2'b11,
      ACS_APPROX = 2'b10
   } acs_state_t;
   typedef struct packed {
      logic [4:0] channel;
      logic sample;
      logic convert;
      logic [1:0] mode;
      logic low_power;
   } acs_core_t;
endpackage

// ---- core/acs_sequencer.sv ----
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "acs_map.svh"
module acs_sequencer import acs_pkg::*; #(
   parameter int DEPTH = 8,
   parameter int STARTUP_CYC = `ACS_STARTUP_CYC
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hw_conv_trigger,
   input wire logic stop_mode,
   input wire logic [11:0] core_result,
   output acs_core_t core_ctrl,
   output logic internal_async_clk,
   output logic conv_irq
);
   // Indices are three bits wide, and warm-up plus bus cycles must fit the wait counter
   if (DEPTH != 8 || STARTUP_CYC < 1 ||
       STARTUP_CYC + `ACS_BUS_CYC > 32'h1000) begin : g_param_check
      $error("acs_sequencer: unsupported parameters");
   end

   // Software-visible control
   logic conv_complete_flag, conv_irq_enable, continuous;
   logic [4:0] input_channel_sel;
   logic hw_trigger_select, compare_enable, compare_upper_limit;
   logic low_power_conv_sel, long_sample_sel;
   logic [1:0] conv_clk_divider, mode, conv_clk_source_sel;
   logic fifo_compare_all_sel;
   logic [2:0] fifo_depth_sel;
   logic [11:0] compare_value_reg;
   logic [4:0] chan_q [DEPTH];
   logic [11:0] res_q [DEPTH];
   logic [2:0] fill, conv_idx, rd_idx;
   logic filled;

   // Sequencer state
   acs_state_t state;
   logic [11:0] wait_cnt;
   logic [5:0] tick_cnt;
   logic [3:0] div_cnt;
   logic first, any_hit, all_hit;

   logic trig_s1, trig_s2, trig_s3, trig_edge;
   logic wr_done, rd_done, wr_sc1, wr_cfg, rd_res;
   logic fifo_on, chan_off, sw_start, hw_start, stop_abort, conversion_clock_tick;
   logic [5:0] sub_ticks, samp_ticks;
   logic [4:0] cur_chan;
   logic [11:0] fitted, cmp_sum, mask;
   logic hit, last_entry;

   function automatic logic [11:0] acs_fit(input logic [11:0] r, input logic [1:0] m);
      logic [10:0] r10;
      logic [8:0] r8;
      r10 = {1'b0, r[11:2]} + {10'h000, r[1]};
      r8 = {1'b0, r[11:4]} + {8'h00, r[3]};
      if (m == `ACS_MODE_8) begin
         acs_fit = r8[8] ? 12'h0ff : {4'h0, r8[7:0]};
      end else if (m == `ACS_MODE_10) begin
         acs_fit = r10[10] ? 12'h3ff : {2'h0, r10[9:0]};
      end else begin
         acs_fit = r;
      end
   endfunction

   assign wr_done = psel && penable && pready && pwrite;
   assign rd_done = psel && penable && pready && !pwrite;
   assign wr_sc1 = wr_done && paddr == `ACS_OFF_SC1;
   assign wr_cfg = wr_done && (paddr == `ACS_OFF_SC2 || paddr == `ACS_OFF_SC3 ||
                               paddr == `ACS_OFF_SC4 || paddr == `ACS_OFF_CV);
   assign rd_res = rd_done && paddr == `ACS_OFF_RES;
   assign fifo_on = fifo_depth_sel != 3'h0;
   assign chan_off = input_channel_sel == `ACS_CHAN_OFF;
   assign filled = fill == fifo_depth_sel;
   assign stop_abort = stop_mode && conv_clk_source_sel != `ACS_SRC_ASYNC;
   assign trig_edge = trig_s2 && !trig_s3;
   assign cur_chan = fifo_on ? chan_q[conv_idx] : input_channel_sel;
   // In FIFO mode only the write that completes the refill starts; a write during
   // a batch or after a full one begins again at entry 0, as the fill logic does
   assign sw_start = wr_sc1 && !hw_trigger_select && pwdata[4:0] != `ACS_CHAN_OFF &&
                     (!fifo_on || (state != ACS_IDLE || filled ? fifo_depth_sel == 3'h1
                                                              : fill + 3'h1 == fifo_depth_sel));
   // Edges count only while idle, so a running series never restarts
   assign hw_start = trig_edge && hw_trigger_select && state == ACS_IDLE && !chan_off &&
                     (!fifo_on || filled);
   assign samp_ticks = long_sample_sel ? 6'(`ACS_SAMP_LONG) : 6'(`ACS_SAMP_SHORT);
   always_comb begin
      if (mode == `ACS_MODE_8) begin
         sub_ticks = long_sample_sel ? 6'(`ACS_SUB_8L) : 6'(`ACS_SUB_8S);
      end else begin
         sub_ticks = long_sample_sel ? 6'(`ACS_SUB_HL) : 6'(`ACS_SUB_HS);
      end
   end
   assign mask = mode == `ACS_MODE_8 ? 12'h0ff : (mode == `ACS_MODE_10 ? 12'h3ff : 12'hfff);
   assign fitted = acs_fit(core_result, mode);
   assign cmp_sum = (fitted + ~compare_value_reg) & mask;
   assign hit = compare_upper_limit ? fitted >= (compare_value_reg & mask)
                                    : fitted < (compare_value_reg & mask);
   assign last_entry = !fifo_on || conv_idx + 3'h1 == fifo_depth_sel;
   // Conversion clock is derived from the bus clock; alternate and async sources
   // are approximated by it, which keeps the counts but not the true frequency.
   assign conversion_clock_tick = div_cnt == 4'h0;

   // Stage three only keeps the settled level for the edge detector
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_s3 <= 1'b0;
      end else begin
         trig_s1 <= hw_conv_trigger;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
      end
   end

   // APB slave: one wait-free access phase, answer registered at the setup edge
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pready) begin
         pready <= 1'b1;
         pslverr <= paddr > `ACS_OFF_CV || paddr[1:0] != 2'h0;
         case (paddr)
            `ACS_OFF_SC1: prdata <= {24'h0, conv_complete_flag, conv_irq_enable, continuous,
                                     fifo_on ? cur_chan : input_channel_sel};
            `ACS_OFF_SC2: prdata <= {24'h0, state != ACS_IDLE, hw_trigger_select,
                                     compare_enable, compare_upper_limit, 4'h0};
            `ACS_OFF_SC3: prdata <= {24'h0, low_power_conv_sel, conv_clk_divider,
                                     long_sample_sel, mode, conv_clk_source_sel};
            `ACS_OFF_SC4: prdata <= {25'h0, fifo_compare_all_sel, 3'h0, fifo_depth_sel};
            `ACS_OFF_RES: prdata <= {20'h0, fifo_on ? res_q[rd_idx] : res_q[0]};
            `ACS_OFF_CV: prdata <= {20'h0, compare_value_reg};
            default: prdata <= 32'h0000_0000;
         endcase
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         conv_irq_enable <= 1'b0;
         continuous <= 1'b0;
         input_channel_sel <= `ACS_CHAN_OFF;
         hw_trigger_select <= 1'b0;
         compare_enable <= 1'b0;
         compare_upper_limit <= 1'b0;
         low_power_conv_sel <= 1'b0;
         conv_clk_divider <= 2'h0;
         long_sample_sel <= 1'b0;
         mode <= 2'h0;
         conv_clk_source_sel <= 2'h0;
         fifo_compare_all_sel <= 1'b0;
         fifo_depth_sel <= 3'h0;
         compare_value_reg <= 12'h000;
      end else if (wr_done) begin
         case (paddr)
            `ACS_OFF_SC1: begin
               conv_irq_enable <= pwdata[6];
               continuous <= pwdata[5];
               input_channel_sel <= pwdata[4:0];
            end
            `ACS_OFF_SC2: begin
               hw_trigger_select <= pwdata[6];
               compare_enable <= pwdata[5];
               compare_upper_limit <= pwdata[4];
            end
            `ACS_OFF_SC3: begin
               low_power_conv_sel <= pwdata[7];
               conv_clk_divider <= pwdata[6:5];
               long_sample_sel <= pwdata[4];
               mode <= pwdata[3:2];
               conv_clk_source_sel <= pwdata[1:0];
            end
            `ACS_OFF_SC4: begin
               fifo_compare_all_sel <= pwdata[6];
               fifo_depth_sel <= pwdata[2:0];
            end
            `ACS_OFF_CV: compare_value_reg <= pwdata[11:0];
            default: ;
         endcase
      end
   end

   // Channel FIFO fill; a write after a finished or running batch starts a new one
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fill <= 3'h0;
         for (int i = 0; i < DEPTH; i++) begin
            chan_q[i] <= 5'h00;
         end
      end else if (wr_sc1 && fifo_on) begin
         if (state != ACS_IDLE || filled) begin
            chan_q[0] <= pwdata[4:0];
            fill <= 3'h1;
         end else begin
            chan_q[fill] <= pwdata[4:0];
            fill <= fill + 3'h1;
         end
      end
   end

   // Source 01 doubles the reload, so one tick spans twice the divided period
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= 4'h0;
      end else if (state == ACS_IDLE || conversion_clock_tick) begin
         div_cnt <= 4'((4'h1 << conv_clk_divider) - 4'h1 +
                       (conv_clk_source_sel == `ACS_SRC_HALF ? (4'h1 << conv_clk_divider) : 4'h0));
      end else begin
         div_cnt <= div_cnt - 4'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= ACS_IDLE;
         wait_cnt <= 12'h000;
         tick_cnt <= 6'h00;
         first <= 1'b1;
         conv_idx <= 3'h0;
         any_hit <= 1'b0;
         all_hit <= 1'b1;
         conv_complete_flag <= 1'b0;
         rd_idx <= 3'h0;
         for (int i = 0; i < DEPTH; i++) begin
            res_q[i] <= 12'h000;
         end
      end else begin
         if (rd_res && fifo_on) begin
            rd_idx <= rd_idx + 3'h1;
         end
         // A completion is assigned further down, so a set in the same cycle wins
         if (rd_res || wr_sc1) begin
            conv_complete_flag <= 1'b0;
         end
         if (sw_start || hw_start) begin
            state <= ACS_WARM;
            first <= 1'b1;
            conv_idx <= 3'h0;
            rd_idx <= 3'h0;
            any_hit <= 1'b0;
            all_hit <= 1'b1;
            wait_cnt <= conv_clk_source_sel == `ACS_SRC_ASYNC ?
                        12'(STARTUP_CYC + `ACS_BUS_CYC - 1) : 12'(`ACS_BUS_CYC - 1);
         end else if (wr_sc1 || wr_cfg || stop_abort || chan_off && !fifo_on) begin
            // Results stay untouched on an abort; only reset clears them
            state <= ACS_IDLE;
            conv_idx <= 3'h0;
         end else begin
            case (state)
               ACS_IDLE: ;
               ACS_WARM: begin
                  if (wait_cnt == 12'h000) begin
                     state <= ACS_SAMPLE;
                     tick_cnt <= 6'h00;
                  end else begin
                     wait_cnt <= wait_cnt - 12'h001;
                  end
               end
               ACS_SAMPLE: begin
                  if (conversion_clock_tick) begin
                     tick_cnt <= tick_cnt + 6'h01;
                     if (tick_cnt + 6'h01 == samp_ticks) begin
                        state <= ACS_APPROX;
                     end
                  end
               end
               ACS_APPROX: begin
                  if (conversion_clock_tick) begin
                     tick_cnt <= tick_cnt + 6'h01;
                  end
                  if (conversion_clock_tick && tick_cnt + 6'h01 ==
                      sub_ticks + (first ? 6'(`ACS_FIRST_EXTRA) : 6'h00)) begin
                     tick_cnt <= 6'h00;
                     first <= 1'b0;
                     // FIFO mode stores every result; the flag waits for the last entry
                     if (fifo_on) begin
                        res_q[conv_idx] <= compare_enable ? cmp_sum : fitted;
                        any_hit <= any_hit || hit;
                        all_hit <= all_hit && hit;
                     end else if (!compare_enable || hit) begin
                        res_q[0] <= compare_enable ? cmp_sum : fitted;
                        conv_complete_flag <= 1'b1;
                     end
                     if (fifo_on && last_entry && (!compare_enable ||
                         (fifo_compare_all_sel ? all_hit && hit : any_hit || hit))) begin
                        conv_complete_flag <= 1'b1;
                     end
                     if (fifo_on && !last_entry) begin
                        conv_idx <= conv_idx + 3'h1;
                        state <= ACS_SAMPLE;
                     end else if (continuous) begin
                        conv_idx <= 3'h0;
                        any_hit <= 1'b0;
                        all_hit <= 1'b1;
                        state <= ACS_SAMPLE;
                     end else begin
                        conv_idx <= 3'h0;
                        state <= ACS_IDLE;
                     end
                  end
               end
               default: state <= ACS_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         core_ctrl <= '0;
         internal_async_clk <= 1'b0;
         conv_irq <= 1'b0;
      end else begin
         core_ctrl.channel <= cur_chan;
         core_ctrl.sample <= state == ACS_SAMPLE;
         core_ctrl.convert <= state == ACS_APPROX;
         core_ctrl.mode <= mode;
         core_ctrl.low_power <= low_power_conv_sel;
         internal_async_clk <= state != ACS_IDLE && conv_clk_source_sel == `ACS_SRC_ASYNC;
         // Level request: stays high while flag and enable are both set
         conv_irq <= conv_complete_flag && conv_irq_enable;
      end
   end
endmodule // acs_sequencer

// ---- sim/acs_core_model.sv ----
`timescale 1ns/100ps
module acs_core_model import acs_pkg::*; (
   input wire logic clk_sys,
   input wire acs_core_t core_ctrl,
   input wire logic [11:0] level,
   output logic [11:0] core_result
);
   logic [11:0] held = 12'h000;
   // The input is followed only while sampling, then held for the approximation
   always @(posedge clk_sys) begin
      if (core_ctrl.sample) held <= level;
   end
   // Outside approximation the value is not valid, so show the inverse
   assign core_result = core_ctrl.convert ? held : ~held;
endmodule // acs_core_model

// ---- sim/acs_sequencer_sva.sv ----
`timescale 1ns/100ps
module acs_sequencer_sva import acs_pkg::*; (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic hw_conv_trigger,
   input wire logic stop_mode,
   input wire logic [11:0] core_result,
   input wire acs_core_t core_ctrl,
   input wire logic internal_async_clk,
   input wire logic conv_irq
);
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire logic busy = core_ctrl.sample | core_ctrl.convert;
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable && pready; endsequence
   a_ready_access: assert property (setup_s |=> access_s)
      else $error("no ready in first access cycle");
   a_ready_single: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   a_err_cause: assert property (pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0))
      else $error("error response does not match address");
   a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_off_idle: assert property (core_ctrl.channel == 5'h1f |-> !busy)
      else $error("converter active on off channel");
   a_isolated_approx: assert property (!(core_ctrl.sample && core_ctrl.convert))
      else $error("sampling during approximation");
   a_sample_length: assert property ($fell(core_ctrl.sample) && core_ctrl.convert |-> $past(core_ctrl.sample, 4))
      else $error("sampling phase too short");
   a_conv_bounded: assert property ($rose(core_ctrl.sample) |-> ##[1:700] !busy)
      else $error("conversion overran its bound");
   a_stop_abort: assert property ($rose(stop_mode) && busy && !internal_async_clk |-> ##[1:3] !busy)
      else $error("stop did not abort");
   a_irq_after_conv: assert property ($rose(conv_irq) |-> $past(core_ctrl.convert, 1) || $past(core_ctrl.convert, 2) || $past(core_ctrl.convert, 3))
      else $error("interrupt without a finished conversion");
endmodule // acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva acs_sequencer_sva_inst (.clk_sys(clk_sys), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_conv_trigger(hw_conv_trigger),
   .stop_mode(stop_mode), .core_result(core_result), .core_ctrl(core_ctrl),
   .internal_async_clk(internal_async_clk), .conv_irq(conv_irq));

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
module testbench;
   import acs_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hw_conv_trigger = 1'b0, stop_mode = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic pready, pslverr, conv_irq, internal_async_clk, ev, async_seen = 1'b0;
   logic [11:0] core_result, level = 12'h000;
   acs_core_t core_ctrl;
   int err_count = 0, n_tests = 0, cycles = 0, n, t0;
   logic [31:0] c_sc2 [3] = '{32'h30, 32'h30, 32'h20};
   logic [11:0] c_lv [3] = '{12'h100, 12'h0ff, 12'h0ff};
   logic [31:0] c_fl [3] = '{32'h1, 32'h0, 32'h1};
   logic [31:0] c_rs [3] = '{32'hfff, 32'hfff, 32'hffe};
   logic [31:0] m_rs [4] = '{32'hab, 32'hab0, 32'h2ac, 32'hab0};
   acs_sequencer #(.STARTUP_CYC(3)) acs_sequencer_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_conv_trigger(hw_conv_trigger),
      .stop_mode(stop_mode), .core_result(core_result), .core_ctrl(core_ctrl),
      .internal_async_clk(internal_async_clk), .conv_irq(conv_irq));
   acs_core_model acs_core_model_inst (.clk_sys(clk_sys), .core_ctrl(core_ctrl), .level(level),
      .core_result(core_result));
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (internal_async_clk === 1'b1) async_seen <= 1'b1;
      if (cycles == 6000) begin
         err_count++;
         finish_test();
      end
   end
   task finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task check(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Only the global cycle ceiling ends a wait for the slave
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_irq();
      n = 0;
      while (conv_irq !== 1'b1 && n < 900) begin
         @(posedge clk_sys);
         n++;
      end
   endtask
   task wait_fall();
      n = 0;
      while (core_ctrl.convert !== 1'b1 && n < 900) begin
         @(posedge clk_sys);
         n++;
      end
      while (core_ctrl.convert !== 1'b0 && n < 900) begin
         @(posedge clk_sys);
         n++;
      end
   endtask
   task t_regs();
      apb(1'b0, 8'h00, 32'h0);
      check(rv, 32'h1f);
      apb(1'b1, 8'h18, 32'hff);
      apb(1'b0, 8'h18, 32'h0);
      check({31'h0, ev}, 32'h1);
      check(rv, 32'h0);
      $display("register test done");
   endtask
   task t_modes();
      level = 12'hab0;
      for (int m = 0; m < 4; m++) begin
         // Last pass: long sample on the internal clock, the slowest first conversion
         apb(1'b1, 8'h08, (m == 3) ? 32'h1f : 32'(m << 2));
         async_seen = 1'b0;
         apb(1'b1, 8'h00, 32'h43);
         wait_irq();
         check(32'(n <= ((m == 3) ? 54 : (m == 0) ? 28 : 31)), 32'h1);
         check({31'h0, async_seen}, 32'(m == 3));
         apb(1'b0, 8'h00, 32'h0);
         check(rv, 32'hc3);
         apb(1'b0, 8'h10, 32'h0);
         check(rv, m_rs[m]);
      end
      $display("mode test done");
   endtask
   task t_abort(input int kind);
      level = 12'h123;
      apb(1'b1, 8'h08, 32'h04);
      apb(1'b1, 8'h00, 32'h43);
      repeat (12) @(posedge clk_sys);
      if (kind == 0) apb(1'b1, 8'h04, 32'h0);
      else if (kind == 1) stop_mode <= 1'b1;
      else begin
         // Restart on a new level: the aborted conversion must not finish
         level = 12'h456;
         apb(1'b1, 8'h00, 32'h43);
      end
      repeat (60) @(posedge clk_sys);
      stop_mode <= 1'b0;
      check({31'h0, conv_irq}, 32'(kind == 2));
      apb(1'b0, 8'h10, 32'h0);
      check(rv, (kind == 2) ? 32'h456 : 32'hab0);
      $display("abort test done");
   endtask
   task t_hw();
      level = 12'h123;
      apb(1'b1, 8'h04, 32'h40);
      apb(1'b1, 8'h00, 32'h43);
      repeat (40) @(posedge clk_sys);
      check({31'h0, conv_irq}, 32'h0);
      t0 = cycles;
      for (int p = 0; p < 2; p++) begin
         // The second edge lands mid-conversion
         hw_conv_trigger <= 1'b1;
         repeat (3) @(posedge clk_sys);
         hw_conv_trigger <= 1'b0;
         repeat (10) @(posedge clk_sys);
      end
      wait_irq();
      check(32'(cycles - t0 <= 34), 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      check(rv, 32'h123);
      repeat (60) @(posedge clk_sys);
      check({31'h0, conv_irq}, 32'h0);
      // Continuous series from one edge; the later edge must not restart it
      apb(1'b1, 8'h00, 32'h23);
      for (int p = 0; p < 2; p++) begin
         hw_conv_trigger <= 1'b1;
         repeat (3) @(posedge clk_sys);
         hw_conv_trigger <= 1'b0;
         repeat (20) @(posedge clk_sys);
      end
      wait_fall();
      check(32'(n <= 7), 32'h1);
      wait_fall();
      check(32'(n <= 20), 32'h1);
      apb(1'b1, 8'h04, 32'h0);
      repeat (3) @(posedge clk_sys);
      check({31'h0, core_ctrl.sample | core_ctrl.convert}, 32'h0);
      $display("trigger test done");
   endtask
   task t_cont();
      level = 12'h5a0;
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h00, 32'h23);
      wait_fall();
      wait_fall();
      check(32'(n <= 17), 32'h1);
      apb(1'b1, 8'h00, 32'h1f);
      repeat (60) @(posedge clk_sys);
      check({31'h0, core_ctrl.sample | core_ctrl.convert}, 32'h0);
      $display("continuous test done");
   endtask
   task t_cmp();
      // Compare is never combined with continuous FIFO operation here
      apb(1'b1, 8'h08, 32'h04);
      apb(1'b1, 8'h14, 32'h100);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 8'h04, c_sc2[i]);
         level = c_lv[i];
         apb(1'b1, 8'h00, 32'h43);
         repeat (60) @(posedge clk_sys);
         apb(1'b0, 8'h00, 32'h0);
         check({31'h0, rv[7]}, c_fl[i]);
         apb(1'b0, 8'h10, 32'h0);
         check(rv, c_rs[i]);
      end
      apb(1'b1, 8'h04, 32'h0);
      $display("compare test done");
   endtask
   task t_fifo();
      level = 12'h321;
      apb(1'b1, 8'h0c, 32'h02);
      apb(1'b1, 8'h00, 32'h41);
      repeat (40) @(posedge clk_sys);
      check({31'h0, conv_irq}, 32'h0);
      apb(1'b1, 8'h00, 32'h42);
      wait_irq();
      check(32'(n > 28 && n <= 62), 32'h1);
      for (int i = 0; i < 2; i++) begin
         apb(1'b0, 8'h10, 32'h0);
         check(rv, 32'h321);
      end
      // Compare in FIFO mode: results always stored, flag by any or all hits
      apb(1'b1, 8'h14, 32'h100);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, 8'h04, (k == 0) ? 32'h20 : 32'h30);
         apb(1'b1, 8'h0c, (k == 0) ? 32'h02 : 32'h42);
         apb(1'b1, 8'h00, 32'h01);
         apb(1'b1, 8'h00, 32'h02);
         repeat (70) @(posedge clk_sys);
         apb(1'b0, 8'h00, 32'h0);
         check({31'h0, rv[7]}, 32'(k));
         for (int i = 0; i < 2; i++) begin
            apb(1'b0, 8'h10, 32'h0);
            check(rv, 32'h220);
         end
      end
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h0c, 32'h0);
      $display("fifo test done");
   endtask
   task t_reset();
      apb(1'b1, 8'h00, 32'h43);
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      apb(1'b0, 8'h10, 32'h0);
      check(rv, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      check(rv, 32'h1f);
      $display("reset test done");
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_regs();
      t_modes();
      t_abort(0);
      t_abort(1);
      t_abort(2);
      t_hw();
      t_cont();
      t_cmp();
      t_fifo();
      t_reset();
      finish_test();
   end
endmodule // testbench
